// File: lvds_fmt_pkg.sv
// Constants for the LVDS output-format control block: register
// offsets, field positions, reset values and write masks.
// Assumes an 8-bit register port addressed by the printed offsets.
package lvds_fmt_pkg;

    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 8;
    localparam int COLOUR_W = 8;
    localparam int LANE_W = 7;

    // Register offsets
    localparam logic [REG_ADDR_W-1:0] OUT_FORMAT_ADDR = 8'h18;
    localparam logic [REG_ADDR_W-1:0] OUT_LEVEL_ADDR = 8'h19;

    // lvds_output_format fields
    localparam int DE_POL_BIT = 7;
    localparam int HS_POL_BIT = 6;
    localparam int VS_POL_BIT = 5;
    localparam int WIDE_SEL_BIT = 3;
    localparam int PLACE_BIT = 1;

    // lvds_output_level fields
    localparam int CM_SEL_BIT = 6;
    localparam int SWING_LSB = 2;
    localparam int SWING_W = 2;

    // Reset values
    localparam logic [REG_DATA_W-1:0] OUT_FORMAT_RESET = 8'h60;
    localparam logic [REG_DATA_W-1:0] OUT_LEVEL_RESET = 8'h04;

    // Writable bits; all others are reserved
    localparam logic [REG_DATA_W-1:0] OUT_FORMAT_WMASK = 8'hea;
    localparam logic [REG_DATA_W-1:0] OUT_LEVEL_WMASK = 8'h4c;

    // Unused top bit of the fourth lane word
    localparam logic LANE3_SPARE = 1'b0;

endpackage : lvds_fmt_pkg

// File: lvds_output_format_control.sv
// LVDS output-format control: two configuration registers and the
// per-pixel formatter that builds the four 7-bit lane words.
// Assumes the pixel source runs on clock_i with active-high DE/HS/VS,
// colours MSB-aligned (18-bit sources sit in bits 7:2), and a serialiser
// downstream that shifts each lane word out MSB first.
`timescale 1ns/1ps

// Summary of operation
// - Output DE is high during active pixels unless its polarity bit is set.
// - Output HS is high during sync unless its polarity bit, reset set, is set.
// - Output VS is high during sync unless its polarity bit, reset set, is set.
// - Depth bit clear gives 18-bit output, fourth lane off; set gives 24-bit.
// - In 24-bit mode fourth lane carries colour MSBs, or LSBs if placement set.
// - Depth clear drops two LSBs per colour for 18-bit output, whatever placement is.
module lvds_output_format_control
    import lvds_fmt_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [REG_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [REG_DATA_W-1:0] reg_rdata_o,
    input wire logic pix_de_i,
    input wire logic pix_hs_i,
    input wire logic pix_vs_i,
    input wire logic [COLOUR_W-1:0] pix_red_i,
    input wire logic [COLOUR_W-1:0] pix_green_i,
    input wire logic [COLOUR_W-1:0] pix_blue_i,
    output logic [LANE_W-1:0] lane0_o,
    output logic [LANE_W-1:0] lane1_o,
    output logic [LANE_W-1:0] lane2_o,
    output logic [LANE_W-1:0] lane3_o,
    output logic fourth_data_lane_en_o,
    output logic lvds_de_o,
    output logic lvds_hs_o,
    output logic lvds_vs_o,
    output logic output_common_mode_select_o,
    output logic [SWING_W-1:0] output_swing_select_o
);

    logic [REG_DATA_W-1:0] out_format_q;
    logic [REG_DATA_W-1:0] out_format_d;
    logic [REG_DATA_W-1:0] out_level_q;
    logic [REG_DATA_W-1:0] out_level_d;
    logic [REG_DATA_W-1:0] rdata_q;
    logic [REG_DATA_W-1:0] rdata_d;

    // Settings in force on the pixel path
    logic de_pol_q;
    logic hs_pol_q;
    logic vs_pol_q;
    logic wide_q;
    logic place_q;

    logic [LANE_W-1:0] lane0_q;
    logic [LANE_W-1:0] lane1_q;
    logic [LANE_W-1:0] lane2_q;
    logic [LANE_W-1:0] lane3_q;
    logic lane_en_q;
    logic de_q;
    logic hs_q;
    logic vs_q;

    // Register decode
    wire sel_format = (reg_addr_i == OUT_FORMAT_ADDR);
    wire sel_level = (reg_addr_i == OUT_LEVEL_ADDR);
    wire wr_format = reg_we_i && sel_format;
    wire wr_level = reg_we_i && sel_level;

    // Reserved positions keep their zero default whatever is written
    assign out_format_d = wr_format ?
        ((out_format_q & ~OUT_FORMAT_WMASK) | (reg_wdata_i & OUT_FORMAT_WMASK)) :
        out_format_q;
    assign out_level_d = wr_level ?
        ((out_level_q & ~OUT_LEVEL_WMASK) | (reg_wdata_i & OUT_LEVEL_WMASK)) :
        out_level_q;

    // Unmapped addresses and reserved bits read as zero
    wire [REG_DATA_W-1:0] format_view = out_format_q & OUT_FORMAT_WMASK;
    wire [REG_DATA_W-1:0] level_view = out_level_q & OUT_LEVEL_WMASK;
    wire [REG_DATA_W-1:0] read_mux = sel_format ? format_view :
                                     sel_level ? level_view : '0;
    assign rdata_d = reg_re_i ? read_mux : '0;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_format_q <= OUT_FORMAT_RESET;
            out_level_q <= OUT_LEVEL_RESET;
            rdata_q <= '0;
        end else if (ce_i) begin
            out_format_q <= out_format_d;
            out_level_q <= out_level_d;
            rdata_q <= rdata_d;
        end
    end

    // Settings reach the pixel path only outside active pixels, so a
    // write mid-line never tears a line; cost is a delay up to one line.
    wire cfg_load = !pix_de_i;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            de_pol_q <= OUT_FORMAT_RESET[DE_POL_BIT];
            hs_pol_q <= OUT_FORMAT_RESET[HS_POL_BIT];
            vs_pol_q <= OUT_FORMAT_RESET[VS_POL_BIT];
            wide_q <= OUT_FORMAT_RESET[WIDE_SEL_BIT];
            place_q <= OUT_FORMAT_RESET[PLACE_BIT];
        end else if (ce_i && cfg_load) begin
            de_pol_q <= out_format_q[DE_POL_BIT];
            hs_pol_q <= out_format_q[HS_POL_BIT];
            vs_pol_q <= out_format_q[VS_POL_BIT];
            wide_q <= out_format_q[WIDE_SEL_BIT];
            place_q <= out_format_q[PLACE_BIT];
        end
    end

    // Control bits in the polarity the panel expects
    wire de_d = pix_de_i ^ de_pol_q;
    wire hs_d = pix_hs_i ^ hs_pol_q;
    wire vs_d = pix_vs_i ^ vs_pol_q;

    // Per colour: six bits for lanes 0-2 and two for the fourth lane.
    // An 18-bit source is taken as MSB-aligned, which the host keeps
    // consistent by leaving the depth bit clear for such streams.
    logic [COLOUR_W-1:0] colour_in [3];
    logic [5:0] low_six [3];
    logic [1:0] top_two [3];

    assign colour_in[0] = pix_red_i;
    assign colour_in[1] = pix_green_i;
    assign colour_in[2] = pix_blue_i;

    // High six bits go on lanes 0-2 unless 24-bit with MSBs on lane four
    wire use_high_six = !wide_q || place_q;

    for (genvar c = 0; c < 3; c++) begin : g_colour
        assign low_six[c] = use_high_six ? colour_in[c][7:2] : colour_in[c][5:0];
        assign top_two[c] = place_q ? colour_in[c][1:0] : colour_in[c][7:6];
    end

    wire [LANE_W-1:0] lane0_d = {low_six[1][0], low_six[0]};
    wire [LANE_W-1:0] lane1_d = {low_six[2][1:0], low_six[1][5:1]};
    wire [LANE_W-1:0] lane2_d = {de_d, vs_d, hs_d, low_six[2][5:2]};
    wire [LANE_W-1:0] lane3_word = {LANE3_SPARE, top_two[2], top_two[1], top_two[0]};
    // Disabled lane idles at zero so no stale LSBs leak to an 18-bit panel
    wire [LANE_W-1:0] lane3_d = wide_q ? lane3_word : '0;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lane0_q <= '0;
            lane1_q <= '0;
            lane2_q <= '0;
            lane3_q <= '0;
            lane_en_q <= 1'b0;
            de_q <= 1'b0;
            hs_q <= 1'b0;
            vs_q <= 1'b0;
        end else if (ce_i) begin
            lane0_q <= lane0_d;
            lane1_q <= lane1_d;
            lane2_q <= lane2_d;
            lane3_q <= lane3_d;
            lane_en_q <= wide_q;
            de_q <= de_d;
            hs_q <= hs_d;
            vs_q <= vs_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign lane0_o = lane0_q;
    assign lane1_o = lane1_q;
    assign lane2_o = lane2_q;
    assign lane3_o = lane3_q;
    assign fourth_data_lane_en_o = lane_en_q;
    assign lvds_de_o = de_q;
    assign lvds_hs_o = hs_q;
    assign lvds_vs_o = vs_q;
    // Analog settings pass straight from the register to the driver
    assign output_common_mode_select_o = out_level_q[CM_SEL_BIT];
    assign output_swing_select_o = out_level_q[SWING_LSB +: SWING_W];

endmodule : lvds_output_format_control

// File: lvds_fmt_sva.sv
// Port assertions for the LVDS output-format block.
// Assumes a bind to lvds_output_format_control; one clock domain.
`timescale 1ns/1ps
module lvds_fmt_sva
    import lvds_fmt_pkg::*;
(
    input wire logic clock_i, rst_b_i, ce_i, reg_we_i, reg_re_i,
    input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pix_red_i,
    input wire logic pix_de_i, pix_hs_i, pix_vs_i, fourth_data_lane_en_o,
    input wire logic lvds_de_o, lvds_hs_o, lvds_vs_o,
    input wire logic [6:0] lane0_o, lane3_o
);
    logic [7:0] fmt_q, shd_q;
    wire logic wr_fmt = ce_i && reg_we_i && reg_addr_i == OUT_FORMAT_ADDR;
    wire logic [7:0] fmt_d = wr_fmt ? (reg_wdata_i & OUT_FORMAT_WMASK) : fmt_q;
    // Shadow tracks the register only between lines, as the pixel path does
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fmt_q <= OUT_FORMAT_RESET;
            shd_q <= OUT_FORMAT_RESET;
        end else begin
            fmt_q <= fmt_d;
            shd_q <= (ce_i && !pix_de_i) ? fmt_q : shd_q;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    sequence rd_fmt_s;
        ce_i && reg_re_i && reg_addr_i == OUT_FORMAT_ADDR;
    endsequence
    de_polarity_a: assert property (ce_i |=> lvds_de_o == ($past(pix_de_i) ^ $past(shd_q[7])))
        else $error("data enable polarity wrong");
    hs_polarity_a: assert property (ce_i |=> lvds_hs_o == ($past(pix_hs_i) ^ $past(shd_q[6])))
        else $error("hsync polarity wrong");
    vs_polarity_a: assert property (ce_i |=> lvds_vs_o == ($past(pix_vs_i) ^ $past(shd_q[5])))
        else $error("vsync polarity wrong");
    lane_enable_a: assert property (ce_i |=> fourth_data_lane_en_o == $past(shd_q[3]))
        else $error("fourth lane enable wrong");
    lane_off_a: assert property (!fourth_data_lane_en_o |-> lane3_o == 7'h00)
        else $error("disabled lane not quiet");
    msb_place_a: assert property (ce_i && shd_q[3] && !shd_q[1] |=> lane3_o[1:0] == $past(pix_red_i[7:6]))
        else $error("fourth lane lacks colour msbs");
    drop_lsb_a: assert property (ce_i && !shd_q[3] |=> lane0_o[5:0] == $past(pix_red_i[7:2]))
        else $error("narrow output keeps low bits");
    read_fmt_a: assert property (rd_fmt_s |=> reg_rdata_o == $past(fmt_q))
        else $error("format readback wrong");
    rdata_idle_a: assert property (ce_i && !reg_re_i |=> reg_rdata_o == 8'h00)
        else $error("read data not cleared");
endmodule : lvds_fmt_sva

// File: lvds_panel_model.sv
// Behavioural LVDS panel: unpacks lane words into fields.
// Assumes lane words already deserialised, one per pixel.
`timescale 1ns/1ps
module lvds_panel_model (
    input wire logic [6:0] lane0_i,
    input wire logic [6:0] lane2_i,
    input wire logic [6:0] lane3_i,
    output logic [7:0] red_o,
    output logic [2:0] ctl_o
);
    assign red_o = {lane3_i[1:0], lane0_i[5:0]};
    assign ctl_o = lane2_i[6:4];
endmodule : lvds_panel_model

// File: tb.sv
// Self-checking bench for the LVDS output-format block.
// Assumes the checker and panel model are compiled first.
`timescale 1ns/1ps
module tb;
    import lvds_fmt_pkg::*;
    logic clock_i = 0, rst_b_i = 0, we = 0, re = 0, de = 0, hs = 0, vs = 0, ce = 1;
    logic [7:0] addr = 0, wdata = 0, red = 0, rdata, p_red;
    logic [6:0] l0, l1, l2, l3;
    logic [2:0] p_ctl;
    logic en, o_de, o_hs, o_vs, cm;
    logic [1:0] swing;
    logic [7:0] cfgs [6] = '{8'h00, 8'he0, 8'h08, 8'h0a, 8'h02, 8'h60};
    int fails = 0, comparisons = 0, cyc = 0;
    always #5 clock_i = ~clock_i;
    lvds_output_format_control dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .pix_de_i(de), .pix_hs_i(hs), .pix_vs_i(vs),
        .pix_red_i(red), .pix_green_i(red), .pix_blue_i(red), .lane0_o(l0),
        .lane1_o(l1), .lane2_o(l2), .lane3_o(l3), .fourth_data_lane_en_o(en),
        .lvds_de_o(o_de), .lvds_hs_o(o_hs), .lvds_vs_o(o_vs),
        .output_common_mode_select_o(cm), .output_swing_select_o(swing));
    lvds_panel_model panel (.lane0_i(l0), .lane2_i(l2), .lane3_i(l3), .red_o(p_red),
        .ctl_o(p_ctl));
    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        {addr, wdata, we} <= {a, d, 1'b1};
        @(posedge clock_i);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        {addr, re} <= {a, 1'b1};
        @(posedge clock_i);
        re <= 1'b0;
        #1 cmp("rdata", exp, rdata);
    endtask : rd
    // Config only changes with DE low; the shadow loads on the first of the two idle edges
    task automatic pix(input logic [7:0] cfg);
        wr(OUT_FORMAT_ADDR, cfg);
        repeat (2) @(posedge clock_i);
        {de, hs, vs, red} <= {3'b110, 8'h9d};
        @(posedge clock_i);
        {de, hs, vs} <= 3'b000;
        #1 cmp("panel_ctl", {5'b0, ~cfg[7], cfg[5], ~cfg[6]}, {5'b0, p_ctl});
        cmp("ctl", {5'b0, ~cfg[7], ~cfg[6], cfg[5]}, {5'b0, o_de, o_hs, o_vs});
        cmp("lane_en", {7'b0, cfg[3]}, {7'b0, en});
        cmp("red6", (!cfg[3] || cfg[1]) ? 8'h27 : 8'h1d, {2'b0, p_red[5:0]});
        cmp("lane1", (!cfg[3] || cfg[1]) ? 8'h73 : 8'h2e, {1'b0, l1});
        cmp("lane2_blue", (!cfg[3] || cfg[1]) ? 8'h09 : 8'h07, {4'b0, l2[3:0]});
        cmp("lane3", cfg[3] ? (cfg[1] ? 8'h01 : 8'h02) : 8'h00, {6'b0, p_red[7:6]});
    endtask : pix
    task automatic end_of_test;
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 1000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(OUT_FORMAT_ADDR, OUT_FORMAT_RESET);
        rd(OUT_LEVEL_ADDR, OUT_LEVEL_RESET);
        wr(OUT_LEVEL_ADDR, 8'hff);
        rd(OUT_LEVEL_ADDR, OUT_LEVEL_WMASK);
        cmp("level_pins", 8'h07, {5'b0, cm, swing});
        wr(OUT_FORMAT_ADDR, 8'hff);
        rd(OUT_FORMAT_ADDR, OUT_FORMAT_WMASK);
        rd(8'h20, 8'h00);
        // Clock enable low must freeze the registers, so this write is lost
        @(posedge clock_i);
        ce <= 1'b0;
        wr(OUT_LEVEL_ADDR, 8'h00);
        @(posedge clock_i);
        ce <= 1'b1;
        rd(OUT_LEVEL_ADDR, OUT_LEVEL_WMASK);
        foreach (cfgs[i]) pix(cfgs[i]);
        end_of_test();
    end
endmodule : tb
bind lvds_output_format_control lvds_fmt_sva chk (.*);
